/* File: bench/freq_ref_assertions.sv */
// Purpose: port-level checks of the frequency reference selector
// Assumes: function codes at reset values
// Notes:   bound into the top module below
`timescale 1ns/10ps
module freq_ref_assertions
#(
  parameter int W = 16
)
(
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   hsel,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic                   step_sel_in_a,
  input wire logic                   step_sel_bit1_in,
  input wire logic                   step_sel_bit2_in,
  input wire logic                   jog_sel_in,
  input wire logic [W-1:0]           freq_ref,
  input wire freq_ref_pkg::ref_idx_t ref_idx,
  input wire logic [7:0]             carrier_freq,
  input wire logic                   setting_error_flag,
  input wire logic                   irq
);
  import freq_ref_pkg::*;
  // ==========
  // properties
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_JOG_WINS:
    assert property (jog_sel_in |=> ref_idx == IDX_JOG)
    else $error("jog not taken");
  AST_STEP_DECODE:
    assert property (!jog_sel_in |=> ref_idx == {1'b0, $past(step_sel_bit2_in),
      $past(step_sel_bit1_in) | $past(step_sel_in_a)})
    else $error("step decode");
  AST_STEP_A_IS_BIT1:
    assert property (step_sel_in_a && !jog_sel_in |=> ref_idx[0])
    else $error("input a ignored");
  AST_MAX_STEPS:
    assert property (ref_idx <= IDX_JOG)
    else $error("index range");
  AST_RESET_FIXED:
    assert property ($rose(hresetn) |-> freq_ref == '0 && carrier_freq == RST_CUPPER
      && !setting_error_flag && !irq)
    else $error("reset outputs");
  AST_NEXT_CYCLE:
    assert property ($changed(jog_sel_in) && $past(hresetn) |=> $changed(ref_idx))
    else $error("selection late");
  AST_HRDATA_HOLDS:
    assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("hrdata moved");
  AST_READY_ALWAYS:
    assert property (hreadyout)
    else $error("wait state");
  AST_OKAY_ONLY:
    assert property (!hresp)
    else $error("error response");
endmodule
bind frequency_reference_selector freq_ref_assertions #(.W(W)) chk_i
(
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .step_sel_in_a, .step_sel_bit1_in, .step_sel_bit2_in, .jog_sel_in,
  .freq_ref, .ref_idx, .carrier_freq, .setting_error_flag, .irq
);

/* File: bench/tb_frequency_reference_selector.sv */
// Purpose: self-checking bench of the frequency reference selector
// Assumes: single bus master, function codes left at reset values
// Notes:   pins driven by the terminal model
`timescale 1ns/10ps
module tb_frequency_reference_selector;
  import freq_ref_pkg::*;
  localparam logic [15:0] A1V = 16'h1200;
  localparam logic [15:0] A2V = 16'h0034;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [4:0]  cmd = '0;
  logic [15:0] out_freq = '0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, ain2_current_mode, irq, setting_error_flag;
  logic        step_sel_in_a, step_sel_bit1_in, step_sel_bit2_in, jog_sel_in;
  logic [15:0] analog_in_first, analog_in_second, serial_ref, option_ref, freq_ref;
  logic [7:0]  carrier_freq;
  ref_idx_t    ref_idx;
  int          errors = 0;
  int          comparisons = 0;
  // ==========
  // clock, far side and design
  always #20 hclk = ~hclk;
  terminal_model #(.A1V(A1V), .A2V(A2V)) pm
  (
    .cmd, .analog_in_first, .analog_in_second, .ain2_current_mode, .serial_ref,
    .option_ref, .step_sel_in_a, .step_sel_bit1_in, .step_sel_bit2_in, .jog_sel_in
  );
  frequency_reference_selector uut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .analog_in_first,
    .analog_in_second, .ain2_current_mode, .serial_ref, .option_ref, .step_sel_in_a,
    .step_sel_bit1_in, .step_sel_bit2_in, .jog_sel_in, .out_freq, .freq_ref,
    .ref_idx, .carrier_freq, .setting_error_flag, .irq
  );
  // ==========
  // helpers
  task automatic results();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge hclk);
  endtask
  task automatic wait_rdy();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(hrdata, e);
  endtask
  task automatic fchk(input logic [15:0] e);
    settle();
    chk({16'h0, freq_ref}, {16'h0, e});
  endtask
  task automatic cchk(input logic [7:0] e);
    settle();
    chk({24'h0, carrier_freq}, {24'h0, e});
  endtask
  task automatic ichk(input logic e);
    settle();
    chk({31'h0, irq}, {31'h0, e});
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] s, input logic [4:0] f, input logic sw);
    return {15'h0, sw, 3'h0, f, 6'h0, s};
  endfunction
  // ==========
  // scenarios
  task automatic t_reset();
    cmd <= '0;
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    fchk(A1V + A2V);
    cchk(8'h96);
    rchk(OFS_REF_CFG, 32'h1);
    rchk(OFS_DIN_CFG, 32'h00060403);
    rchk(OFS_CARRIER_CFG, 32'h00009601);
    rchk(OFS_CARRIER_EXT, 32'h0);
    rchk(OFS_LIVE_STATE, 32'h00961234);
  endtask
  task automatic t_source();
    logic [15:0] e [4];
    e = '{16'h0101, A1V + A2V, 16'h5a5a, 16'h0f0f};
    wr(OFS_STEP_REF_1, 32'h0101);
    wr(OFS_STEP_REF_2, 32'h0202);
    for (int s = 0; s < 4; s++)
    begin
      wr(OFS_REF_CFG, cfg(2'(s), AIN2_ADD, 1'b0));
      fchk(e[s]);
    end
    wr(OFS_REF_CFG, cfg(SRC_ANALOG, AIN2_AUX, 1'b0));
    fchk(A1V);
    cmd <= 5'h11;
    fchk(A2V);
    wr(OFS_REF_CFG, cfg(SRC_ANALOG, AIN2_AUX, 1'b1));
    fchk(A1V);
    cmd <= 5'h00;
    fchk(A2V);
    cmd <= 5'h02;
    wr(OFS_REF_CFG, cfg(SRC_ANALOG, AIN2_UNUSED, 1'b0));
    fchk(16'h0202);
  endtask
  task automatic t_steps();
    logic [15:0] v [5];
    logic [2:0]  x;
    v = '{16'h0111, 16'h0222, 16'h0333, 16'h0444, 16'h0555};
    wr(OFS_REF_CFG, cfg(SRC_KEYPAD, AIN2_UNUSED, 1'b0));
    for (int k = 0; k < 4; k++)
      wr(OFS_STEP_REF_1 + 8'(4 * k), {16'h0, v[k]});
    wr(OFS_JOG_REF, {16'h0, v[4]});
    for (int i = 0; i < 8; i++)
    begin
      cmd <= {1'b0, 3'(i), 1'b0};
      x = (i > 3) ? 3'h4 : 3'(i);
      fchk(v[x]);
      chk({29'h0, ref_idx}, {29'h0, x});
    end
    cmd <= '0;
  endtask
  task automatic t_carrier();
    logic [31:0] ec [3], ee [3];
    ec = '{32'h100f, 32'h100f, 32'h300f};
    ee = '{32'h0720, 32'h0620, 32'h0720};
    wr(OFS_CARRIER_CFG, 32'h2001);
    wr(OFS_CARRIER_EXT, 32'h1010);
    rchk(OFS_CARRIER_EXT, 32'h0);
    wr(OFS_CARRIER_CFG, 32'h200f);
    wr(OFS_CARRIER_EXT, 32'h1010);
    rchk(OFS_CARRIER_EXT, 32'h1010);
    out_freq <= 16'h0080;
    cchk(8'h18);
    out_freq <= 16'h0800;
    cchk(8'h20);
    wr(OFS_CARRIER_EXT, 32'h0010);
    cchk(8'h20);
    wr(OFS_CARRIER_CFG, 32'h100f);
    wr(OFS_CARRIER_EXT, 32'h1010);
    cchk(8'h10);
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_CARRIER_CFG, ec[i]);
      wr(OFS_CARRIER_EXT, ee[i]);
      settle();
      chk({31'h0, setting_error_flag}, {31'h0, i == 0});
    end
  endtask
  task automatic t_irq();
    wr(OFS_CARRIER_EXT, 32'h0620);
    wr(OFS_CARRIER_CFG, 32'h100f);
    wr(OFS_INT_CLEAR, 32'h3);
    wr(OFS_CARRIER_EXT, 32'h0720);
    wr(OFS_INT_STATUS, 32'h0);
    ichk(1'b0);
    xfer(OFS_INT_STATUS, 1'b0, 32'h0);
    chk(hrdata & 32'h2, 32'h2);
    wr(OFS_INT_ENABLE, 32'h2);
    ichk(1'b1);
    wr(OFS_INT_CLEAR, 32'h2);
    ichk(1'b0);
    rchk(OFS_INT_CLEAR, 32'h0);
    rchk(8'h40, 32'h0);
    wr(OFS_INT_ENABLE, 32'h1);
    cmd <= 5'h08;
    ichk(1'b1);
    cmd <= 5'h00;
    settle();
    wr(OFS_INT_CLEAR, 32'h1);
    ichk(1'b0);
  endtask
  // ==========
  // sequence and watchdog
  initial
  begin
    t_reset();
    t_source();
    t_steps();
    t_carrier();
    t_irq();
    t_reset();
    results();
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    errors++;
    results();
  end
endmodule

/* File: bench/terminal_model.sv */
// Purpose: control terminal levels seen by the selector
// Assumes: cmd bits {current mode, jog, step2, step1, master/aux}
// Notes:   analog and link values are fixed levels
`timescale 1ns/10ps
module terminal_model
#(
  parameter int           W    = 16,
  parameter logic [W-1:0] A1V  = 16'h1200,
  parameter logic [W-1:0] A2V  = 16'h0034,
  parameter logic [W-1:0] SERV = 16'h5a5a,
  parameter logic [W-1:0] OPTV = 16'h0f0f
)
(
  input  wire logic [4:0]   cmd,
  output logic      [W-1:0] analog_in_first,
  output logic      [W-1:0] analog_in_second,
  output logic              ain2_current_mode,
  output logic      [W-1:0] serial_ref,
  output logic      [W-1:0] option_ref,
  output logic              step_sel_in_a,
  output logic              step_sel_bit1_in,
  output logic              step_sel_bit2_in,
  output logic              jog_sel_in
);
  // ==========
  // terminal levels
  assign analog_in_first   = A1V;
  assign analog_in_second  = A2V;
  assign ain2_current_mode = cmd[4];
  assign serial_ref        = SERV;
  assign option_ref        = OPTV;
  assign step_sel_in_a     = cmd[0];
  assign step_sel_bit1_in  = cmd[1];
  assign step_sel_bit2_in  = cmd[2];
  assign jog_sel_in        = cmd[3];
endmodule

/* File: core/carrier_calc.sv */
// Purpose: carrier frequency from output frequency and limit settings
// Assumes: carrier values in 0.1 kHz units
// Notes:   combinational; result clipped into the limit band
`timescale 1ns/10ps
module carrier_calc
#(
  parameter int W = 16
)
(
  input  wire logic [7:0]   carrier_upper_limit,
  input  wire logic [7:0]   carrier_lower_limit,
  input  wire logic [6:0]   carrier_prop_gain,
  input  wire logic [W-1:0] out_freq,
  output logic      [7:0]   carrier_freq,
  output logic              setting_error
);
  import freq_ref_pkg::*;
  logic [W+6:0] prod;
  logic [W+6:0] ramp;

  // ==========================================================
  // carrier ramp and error check
  always_comb
  begin
    prod = out_freq * carrier_prop_gain;
    ramp = (prod >> CARRIER_SHIFT) + (W+7)'(carrier_lower_limit);
    setting_error = (carrier_prop_gain > GAIN_ERR_LIMIT)
                 && (carrier_upper_limit < carrier_lower_limit); // RL13
    if (carrier_upper_limit == carrier_lower_limit || carrier_prop_gain == GAIN_FIXED)
      carrier_freq = carrier_upper_limit; // RL12
    else if (ramp > (W+7)'(carrier_upper_limit))
      carrier_freq = carrier_upper_limit; // RL12
    else
      carrier_freq = ramp[7:0]; // RL12
  end
endmodule

/* File: core/freq_ref_pkg.sv */
// Purpose: shared constants for the frequency reference selector
// Assumes: AHB-Lite slave with 32-bit words, byte addresses below
// Notes:   reset values marked as plain defaults are neutral choices
package freq_ref_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_REF_CFG     = 8'h00;
  localparam logic [7:0] OFS_DIN_CFG     = 8'h04;
  localparam logic [7:0] OFS_CARRIER_CFG = 8'h08;
  localparam logic [7:0] OFS_CARRIER_EXT = 8'h0c;
  localparam logic [7:0] OFS_STEP_REF_1  = 8'h10;
  localparam logic [7:0] OFS_STEP_REF_2  = 8'h14;
  localparam logic [7:0] OFS_STEP_REF_3  = 8'h18;
  localparam logic [7:0] OFS_STEP_REF_4  = 8'h1c;
  localparam logic [7:0] OFS_JOG_REF     = 8'h20;
  localparam logic [7:0] OFS_INT_STATUS  = 8'h24;
  localparam logic [7:0] OFS_INT_CLEAR   = 8'h28;
  localparam logic [7:0] OFS_INT_ENABLE  = 8'h2c;
  localparam logic [7:0] OFS_LIVE_STATE  = 8'h30;
  // ==========================================================
  // field positions
  localparam int SRC_LSB   = 0;
  localparam int AIN2F_LSB = 8;
  localparam int SWAP_BIT  = 16;
  localparam int DIN4_LSB  = 0;
  localparam int DIN5_LSB  = 8;
  localparam int DIN6_LSB  = 16;
  localparam int CSEL_LSB  = 0;
  localparam int CUP_LSB   = 8;
  localparam int CLOW_LSB  = 0;
  localparam int CGAIN_LSB = 8;
  localparam int LIVE_CAR_LSB = 16;
  localparam int LIVE_ERR_BIT = 24;
  localparam int LIVE_IDX_LSB = 25;
  localparam int INT_W     = 2;
  localparam int INT_CHANGE = 0;
  localparam int INT_SETERR = 1;
  // ==========================================================
  // setting encodings
  localparam logic [1:0] SRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRC_ANALOG = 2'h1;
  localparam logic [1:0] SRC_SERIAL = 2'h2;
  localparam logic [1:0] SRC_OPTION = 2'h3;
  localparam logic [4:0] AIN2_ADD    = 5'h00;
  localparam logic [4:0] AIN2_AUX    = 5'h02;
  localparam logic [4:0] AIN2_UNUSED = 5'h1f;
  localparam logic [7:0] FN_STEP_BIT1 = 8'h03;
  localparam logic [7:0] FN_STEP_BIT2 = 8'h04;
  localparam logic [7:0] FN_JOG_SEL   = 8'h06;
  localparam logic [3:0] CARRIER_SEL_USER = 4'hf;
  localparam logic [6:0] GAIN_ERR_LIMIT   = 7'h06;
  localparam logic [6:0] GAIN_FIXED       = 7'h00;
  // ==========================================================
  // reset values
  localparam logic [1:0] RST_SRC       = SRC_ANALOG;
  localparam logic [4:0] RST_AIN2F     = AIN2_ADD;
  localparam logic [3:0] RST_CSEL      = 4'h1;
  localparam logic [7:0] RST_CUPPER    = 8'h96;
  localparam logic [7:0] RST_CLOWER    = 8'h96;
  localparam logic [6:0] RST_CGAIN     = 7'h00;
  // carrier slope scaling: gain * output frequency >> shift
  localparam int CARRIER_SHIFT = 8;
  // selected reference indices (step 1..4 as 0..3, jog as 4)
  typedef enum logic [2:0] {IDX_STEP1, IDX_STEP2, IDX_STEP3, IDX_STEP4, IDX_JOG} ref_idx_t;
endpackage

/* File: core/frequency_reference_selector.sv */
// Purpose: AHB-Lite controlled frequency reference and carrier selector
// Assumes: inputs synchronous to hclk; analog inputs already digitised
// Notes:   zero wait state slave, always OKAY
`timescale 1ns/10ps
// Operation
// (RL1) source select: keypad, analog, serial, option
// (RL2) first analog voltage, second voltage or current
// (RL3) step bit1 switches master to auxiliary analog
// (RL4) second analog function 0 adds both inputs
// (RL5) swap setting makes second input the master
// (RL6) input codes 3,4,6: step bits, jog
// (RL7) step bits pick stored reference one to four
// (RL8) jog input overrides both step bits
// (RL9) five steps: four stored plus jog
// (RL10) step one: analog or stored reference one
// (RL11) step two: auxiliary analog or stored two
// (RL12) carrier follows frequency, fixed if flat
// (RL13) gain above six with inverted limits errors
// (RL14) lower limit and gain need carrier select F
// (RL15) selection re-evaluated every clock cycle
module frequency_reference_selector
#(
  parameter int W = 16
)
(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic [W-1:0]  analog_in_first,
  input  wire logic [W-1:0]  analog_in_second,
  input  wire logic          ain2_current_mode,
  input  wire logic [W-1:0]  serial_ref,
  input  wire logic [W-1:0]  option_ref,
  input  wire logic          step_sel_in_a,
  input  wire logic          step_sel_bit1_in,
  input  wire logic          step_sel_bit2_in,
  input  wire logic          jog_sel_in,
  input  wire logic [W-1:0]  out_freq,
  output logic      [W-1:0]  freq_ref,
  output freq_ref_pkg::ref_idx_t ref_idx,
  output logic      [7:0]    carrier_freq,
  output logic               setting_error_flag,
  output logic               irq
);
  import freq_ref_pkg::*;

  logic [1:0]    ref_source_sel_reg;
  logic [4:0]    ain2_function_sel_reg;
  logic          ain_swap_sel_reg;
  logic [7:0]    din4_function_reg;
  logic [7:0]    din5_function_reg;
  logic [7:0]    din6_function_reg;
  logic [3:0]    carrier_sel_reg;
  logic [7:0]    carrier_upper_limit_reg;
  logic [7:0]    carrier_lower_limit_reg;
  logic [6:0]    carrier_prop_gain_reg;
  logic [W-1:0]  step_ref_reg [4];
  logic [W-1:0]  jog_ref_reg;
  logic [INT_W-1:0] int_status_reg;
  logic [INT_W-1:0] int_enable_reg;
  logic          dphase_reg;
  logic          dwrite_reg;
  logic [7:0]    daddr_reg;
  logic          addr_ok;
  logic          wr_en;
  logic          step_bit1;
  logic          step_bit2;
  logic          jog_on;
  ref_idx_t      sel_idx;
  logic [W-1:0]  sel_ref;
  logic [7:0]    carrier_next;
  logic          seterr_next;
  logic [INT_W-1:0] int_event;
  logic [INT_W-1:0] int_clear;
  logic [31:0]   hrdata_next;
  logic          user_carrier;

  // ==========================================================
  // input function decode
  function automatic logic din_active(input logic [7:0] code);
    din_active = (din4_function_reg == code && step_sel_bit1_in)
              || (din5_function_reg == code && step_sel_bit2_in)
              || (din6_function_reg == code && jog_sel_in);
  endfunction

  always_comb
  begin
    step_bit1 = din_active(FN_STEP_BIT1) || step_sel_in_a; // RL6
    step_bit2 = din_active(FN_STEP_BIT2); // RL6
    jog_on    = din_active(FN_JOG_SEL); // RL6
  end

  // ==========================================================
  // bus address phase capture
  assign addr_ok   = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = dphase_reg && dwrite_reg;
  assign user_carrier = (carrier_sel_reg == CARRIER_SEL_USER);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dphase_reg <= 1'b0;
      dwrite_reg <= 1'b0;
      daddr_reg  <= 8'h00;
    end
    else
    begin
      dphase_reg <= addr_ok;
      if (addr_ok)
      begin
        dwrite_reg <= hwrite;
        daddr_reg  <= haddr[7:0];
      end
    end
  end

  // ==========================================================
  // read data, registered in the address phase
  always_comb
  begin
    hrdata_next = 32'h0000_0000;
    unique case (haddr[7:0])
      OFS_REF_CFG:
      begin
        hrdata_next[SRC_LSB +: 2]   = ref_source_sel_reg;
        hrdata_next[AIN2F_LSB +: 5] = ain2_function_sel_reg;
        hrdata_next[SWAP_BIT]       = ain_swap_sel_reg;
      end
      OFS_DIN_CFG:
      begin
        hrdata_next[DIN4_LSB +: 8] = din4_function_reg;
        hrdata_next[DIN5_LSB +: 8] = din5_function_reg;
        hrdata_next[DIN6_LSB +: 8] = din6_function_reg;
      end
      OFS_CARRIER_CFG:
      begin
        hrdata_next[CSEL_LSB +: 4] = carrier_sel_reg;
        hrdata_next[CUP_LSB +: 8]  = carrier_upper_limit_reg;
      end
      OFS_CARRIER_EXT:
      begin
        if (user_carrier)
        begin
          hrdata_next[CLOW_LSB +: 8]  = carrier_lower_limit_reg; // RL14
          hrdata_next[CGAIN_LSB +: 7] = carrier_prop_gain_reg; // RL14
        end
      end
      OFS_STEP_REF_1: hrdata_next[W-1:0] = step_ref_reg[0];
      OFS_STEP_REF_2: hrdata_next[W-1:0] = step_ref_reg[1];
      OFS_STEP_REF_3: hrdata_next[W-1:0] = step_ref_reg[2];
      OFS_STEP_REF_4: hrdata_next[W-1:0] = step_ref_reg[3];
      OFS_JOG_REF:    hrdata_next[W-1:0] = jog_ref_reg;
      OFS_INT_STATUS: hrdata_next[INT_W-1:0] = int_status_reg;
      OFS_INT_ENABLE: hrdata_next[INT_W-1:0] = int_enable_reg;
      OFS_LIVE_STATE:
      begin
        hrdata_next[W-1:0]               = freq_ref;
        hrdata_next[LIVE_CAR_LSB +: 8]   = carrier_freq;
        hrdata_next[LIVE_ERR_BIT]        = setting_error_flag;
        hrdata_next[LIVE_IDX_LSB +: 3]   = ref_idx;
      end
      default: hrdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite)
      hrdata <= hrdata_next;
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_source_sel_reg      <= RST_SRC; // RL1
      ain2_function_sel_reg   <= RST_AIN2F; // RL4
      ain_swap_sel_reg        <= 1'b0;
      din4_function_reg       <= FN_STEP_BIT1;
      din5_function_reg       <= FN_STEP_BIT2;
      din6_function_reg       <= FN_JOG_SEL;
      carrier_sel_reg         <= RST_CSEL;
      carrier_upper_limit_reg <= RST_CUPPER;
      carrier_lower_limit_reg <= RST_CLOWER;
      carrier_prop_gain_reg   <= RST_CGAIN;
    end
    else if (wr_en)
    begin
      unique case (daddr_reg)
        OFS_REF_CFG:
        begin
          ref_source_sel_reg    <= hwdata[SRC_LSB +: 2];
          ain2_function_sel_reg <= hwdata[AIN2F_LSB +: 5];
          ain_swap_sel_reg      <= hwdata[SWAP_BIT];
        end
        OFS_DIN_CFG:
        begin
          din4_function_reg <= hwdata[DIN4_LSB +: 8];
          din5_function_reg <= hwdata[DIN5_LSB +: 8];
          din6_function_reg <= hwdata[DIN6_LSB +: 8];
        end
        OFS_CARRIER_CFG:
        begin
          carrier_sel_reg         <= hwdata[CSEL_LSB +: 4];
          carrier_upper_limit_reg <= hwdata[CUP_LSB +: 8];
        end
        OFS_CARRIER_EXT:
        begin
          if (user_carrier)
          begin
            carrier_lower_limit_reg <= hwdata[CLOW_LSB +: 8]; // RL14
            carrier_prop_gain_reg   <= hwdata[CGAIN_LSB +: 7]; // RL14
          end
        end
        default:
        begin
          carrier_sel_reg <= carrier_sel_reg;
        end
      endcase
    end
  end

  // ==========================================================
  // stored step and jog references
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_step
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          step_ref_reg[gi] <= '0;
        else if (wr_en && daddr_reg == OFS_STEP_REF_1 + 8'(4 * gi))
          step_ref_reg[gi] <= hwdata[W-1:0];
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      jog_ref_reg <= '0;
    else if (wr_en && daddr_reg == OFS_JOG_REF)
      jog_ref_reg <= hwdata[W-1:0];
  end

  // ==========================================================
  // reference selection and carrier
  step_ref_mux #(.W(W)) u_mux
  (
    .ref_source_sel    (ref_source_sel_reg),
    .ain2_function_sel (ain2_function_sel_reg),
    .ain_swap_sel      (ain_swap_sel_reg),
    .step_bit1         (step_bit1),
    .step_bit2         (step_bit2),
    .jog_on            (jog_on),
    .analog_in_first   (analog_in_first),
    .analog_in_second  (analog_in_second),
    .serial_ref        (serial_ref),
    .option_ref        (option_ref),
    .step_ref_1        (step_ref_reg[0]),
    .step_ref_2        (step_ref_reg[1]),
    .step_ref_3        (step_ref_reg[2]),
    .step_ref_4        (step_ref_reg[3]),
    .jog_ref           (jog_ref_reg),
    .sel_idx           (sel_idx),
    .sel_ref           (sel_ref)
  );

  carrier_calc #(.W(W)) u_carrier
  (
    .carrier_upper_limit (carrier_upper_limit_reg),
    .carrier_lower_limit (carrier_lower_limit_reg),
    .carrier_prop_gain   (carrier_prop_gain_reg),
    .out_freq            (out_freq),
    .carrier_freq        (carrier_next),
    .setting_error       (seterr_next)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      freq_ref           <= '0;
      ref_idx            <= IDX_STEP1;
      carrier_freq       <= RST_CUPPER;
      setting_error_flag <= 1'b0;
    end
    else
    begin
      freq_ref           <= sel_ref; // RL15
      ref_idx            <= sel_idx; // RL15
      carrier_freq       <= carrier_next; // RL12
      setting_error_flag <= seterr_next; // RL13
    end
  end

  // ==========================================================
  // interrupts
  always_comb
  begin
    int_event = '0;
    int_event[INT_CHANGE] = (sel_idx != ref_idx) || (sel_ref != freq_ref);
    int_event[INT_SETERR] = seterr_next && !setting_error_flag;
    int_clear = '0;
    if (wr_en && daddr_reg == OFS_INT_CLEAR)
      int_clear = hwdata[INT_W-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_status_reg <= '0;
      int_enable_reg <= '0;
    end
    else
    begin
      int_status_reg <= (int_status_reg & ~int_clear) | int_event;
      if (wr_en && daddr_reg == OFS_INT_ENABLE)
        int_enable_reg <= hwdata[INT_W-1:0];
    end
  end

  assign irq = |(int_status_reg & int_enable_reg);

  // the current/voltage choice only affects upstream scaling
  logic unused_ok;
  assign unused_ok = ain2_current_mode ^ (^hsize) ^ (^haddr[31:8]) ^ (^hwdata[31:W]);
endmodule

/* File: core/step_ref_mux.sv */
// Purpose: picks the frequency reference from source, step and jog inputs
// Assumes: all inputs already resolved from pins and settings
// Notes:   purely combinational, re-evaluated every cycle
`timescale 1ns/10ps
module step_ref_mux
#(
  parameter int W = 16
)
(
  input  wire logic [1:0]             ref_source_sel,
  input  wire logic [4:0]             ain2_function_sel,
  input  wire logic                   ain_swap_sel,
  input  wire logic                   step_bit1,
  input  wire logic                   step_bit2,
  input  wire logic                   jog_on,
  input  wire logic [W-1:0]           analog_in_first,
  input  wire logic [W-1:0]           analog_in_second,
  input  wire logic [W-1:0]           serial_ref,
  input  wire logic [W-1:0]           option_ref,
  input  wire logic [W-1:0]           step_ref_1,
  input  wire logic [W-1:0]           step_ref_2,
  input  wire logic [W-1:0]           step_ref_3,
  input  wire logic [W-1:0]           step_ref_4,
  input  wire logic [W-1:0]           jog_ref,
  output freq_ref_pkg::ref_idx_t      sel_idx,
  output logic      [W-1:0]           sel_ref
);
  import freq_ref_pkg::*;
  logic [W-1:0] master;
  logic [W-1:0] aux;
  logic [W:0]   sum;
  logic [W-1:0] step1_val;

  // ==========================================================
  // analog master / auxiliary
  always_comb
  begin
    master = ain_swap_sel ? analog_in_second : analog_in_first; // RL5
    aux    = ain_swap_sel ? analog_in_first : analog_in_second; // RL5
    sum    = {1'b0, master} + {1'b0, aux};
    step1_val = master; // RL2
    if (ain2_function_sel == AIN2_ADD)
    begin
      step1_val = sum[W] ? {W{1'b1}} : sum[W-1:0]; // RL4
    end
  end

  // ==========================================================
  // step and jog selection
  always_comb
  begin
    sel_idx = IDX_STEP1;
    sel_ref = step_ref_1;
    if (jog_on)
    begin
      sel_idx = IDX_JOG; // RL8
      sel_ref = jog_ref; // RL9
    end
    else
    begin
      unique case ({step_bit2, step_bit1}) // RL7
        2'b00:
        begin
          sel_idx = IDX_STEP1;
          unique case (ref_source_sel) // RL1
            SRC_KEYPAD: sel_ref = step_ref_1; // RL10
            SRC_ANALOG: sel_ref = step1_val; // RL10
            SRC_SERIAL: sel_ref = serial_ref;
            SRC_OPTION: sel_ref = option_ref;
          endcase
        end
        2'b01:
        begin
          sel_idx = IDX_STEP2;
          if (ref_source_sel == SRC_ANALOG && ain2_function_sel == AIN2_AUX)
            sel_ref = aux; // RL3 RL11
          else
            sel_ref = step_ref_2; // RL11
        end
        2'b10:
        begin
          sel_idx = IDX_STEP3;
          sel_ref = step_ref_3;
        end
        2'b11:
        begin
          sel_idx = IDX_STEP4;
          sel_ref = step_ref_4;
        end
      endcase
    end
  end
endmodule
